// >>> hdl/adcsx_pkg.sv
// Constants, types and decoders for the converter sequence and extra-conversion control block.
// Assumes one 100 MHz clock and a 32-bit Avalon-MM register slave.
package adcsx_pkg;

   // ----------------------------------------
   // Register indices (byte address = 4 x index)
   // ----------------------------------------
   localparam logic [7:0] IDX_SEQ_CFG = 8'hB5;
   localparam logic [7:0] IDX_EXT_CFG = 8'hB6;
   localparam logic [7:0] IDX_IRQ_STAT = 8'hB7;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hB8;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int REF_LSB = 6;
   localparam int DIV_LSB = 4;
   localparam int CH_LSB = 0;
   localparam int STAT_EXTRA_DONE = 0;
   localparam int STAT_BUSY = 4;
   localparam int STAT_PENDING = 5;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [1:0] SEQUENCE_REFERENCE_SELECT_RST = 2'h0;
   localparam logic [1:0] SEQUENCE_DECIMATION_SELECT_RST = 2'h1;
   localparam logic [3:0] SCH_RST = 4'h0;
   localparam logic [1:0] EXTRA_REFERENCE_SELECT_RST = 2'h0;
   localparam logic [1:0] EXTRA_DECIMATION_SELECT_RST = 2'h0;
   localparam logic [3:0] ECH_RST = 4'h0;
   localparam logic [3:0] RESULT_CH_RST = 4'hF;

   // ----------------------------------------
   // Channel codes
   // ----------------------------------------
   localparam logic [3:0] CH_SINGLE_LAST = 4'h7;
   localparam logic [3:0] CH_DIFF_FIRST = 4'h8;
   localparam logic [3:0] CH_DIFF_LAST = 4'hB;
   localparam logic [3:0] CH_GROUND = 4'hC;
   localparam logic [3:0] CH_POS_REF = 4'hD;
   localparam logic [3:0] CH_TEMP = 4'hE;
   localparam logic [3:0] CH_FIRST_SINGLE = 4'h0;

   // Source kind driven to the analog multiplexer
   localparam logic [1:0] KIND_SINGLE = 2'h0;
   localparam logic [1:0] KIND_DIFF = 2'h1;
   localparam logic [1:0] KIND_INTERNAL = 2'h2;

   typedef enum logic [1:0] {ADCSX_IDLE, ADCSX_SEQ, ADCSX_EXTRA} adcsx_state_t;

   // Decimation code to rate
   function automatic logic [9:0] dec_rate(input logic [1:0] code);
      case (code)
         2'h0: dec_rate = 10'h040;
         2'h1: dec_rate = 10'h080;
         2'h2: dec_rate = 10'h100;
         default: dec_rate = 10'h200;
      endcase
   endfunction : dec_rate

   // Decimation code to resolution in bits
   function automatic logic [3:0] dec_res(input logic [1:0] code);
      case (code)
         2'h0: dec_res = 4'h7;
         2'h1: dec_res = 4'h9;
         2'h2: dec_res = 4'hA;
         default: dec_res = 4'hC;
      endcase
   endfunction : dec_res

   // Channel code to source kind
   function automatic logic [1:0] chan_kind(input logic [3:0] ch);
      if (ch <= CH_SINGLE_LAST) begin
         chan_kind = KIND_SINGLE;
      end else if (ch <= CH_DIFF_LAST) begin
         chan_kind = KIND_DIFF;
      end else begin
         chan_kind = KIND_INTERNAL;
      end
   endfunction : chan_kind

endpackage : adcsx_pkg

// >>> hdl/adcsx_avmm.sv
// Avalon-MM slave front end with one wait cycle per access.
// Assumes the master holds its request until it sees waitrequest low.
`timescale 1ns/10ps
`default_nettype none
module adcsx_avmm (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Register file side
   input wire logic [7:0] rd_data,
   output logic acc_wr,
   output logic [7:0] acc_idx,
   output logic [7:0] acc_wdata
);
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   always_comb begin
      wait_nxt = !((read || write) && wait_r);
      rdata_nxt = rdata_r;
      if (read && wait_r) begin
         rdata_nxt = {24'h0000_00, rd_data};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Write takes effect on the edge where waitrequest is seen low
   assign acc_wr = write && !wait_r && byteenable[0];
   assign acc_idx = address[9:2];
   assign acc_wdata = writedata[7:0];
   assign readdata = rdata_r;
   assign waitrequest = wait_r;

endmodule : adcsx_avmm
`default_nettype wire

// >>> hdl/adcsx_ctrl.sv
// Sequence and extra-conversion control for a delta-sigma converter.
// Assumes conv_done and seq_start come from logic on the same clock.
//
// Behaviour
// - Sequence reference field picks internal, input 7, supply or differential 6-7.
// - Sequence decimation field sets rate and resolution, 64/7 up to 512/12.
// - Sequence end field: 0 to 7 single inputs, 8 to 11 differential pairs.
// - Sequence end above 11 gives a single conversion of that source only.
// - Reading sequence end returns held result channel plus one.
// - Codes 0-7 single, 8-11 pairs, 12 ground, 13 reference, 14 temperature.
// - Extra reference field picks internal, input 7, supply or differential 6-7.
// - Extra decimation: 64/7, 128/9, 256/10, 512/12.
// - Extra conversion requested during a sequence runs after the sequence ends.
// - Extra channel write while idle starts one conversion at once.
// - Extra channel field clears to zero when extra conversion finishes with no extra write in that cycle.
// - Extra fields use the same codes as the sequence fields.
// - Extra completion raises an interrupt; sequence completions raise none.
`timescale 1ns/10ps
`default_nettype none
module adcsx_ctrl (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Converter core
   input wire logic seq_start,
   input wire logic conv_done,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic [1:0] conv_kind,
   output logic [1:0] conv_reference,
   output logic [9:0] conv_decim_rate,
   output logic [3:0] conv_resolution,
   output logic conv_extra,
   // Status
   output logic [3:0] result_channel,
   output logic busy,
   output logic irq
);
   logic acc_wr;
   logic [7:0] acc_idx;
   logic [7:0] acc_wdata;
   logic [7:0] rd_data;
   logic wr_seq;
   logic wr_ext;
   logic last_ch;
   logic [3:0] first_ch;

   adcsx_pkg::adcsx_state_t state_r, state_nxt;
   logic [1:0] sequence_reference_select_r, sequence_reference_select_nxt;
   logic [1:0] sequence_decimation_select_r, sequence_decimation_select_nxt;
   logic [3:0] sch_r, sch_nxt;
   logic [1:0] extra_reference_select_r, extra_reference_select_nxt;
   logic [1:0] extra_decimation_select_r, extra_decimation_select_nxt;
   logic [3:0] ech_r, ech_nxt;
   logic pend_r, pend_nxt;
   logic [3:0] seq_ch_r, seq_ch_nxt;
   logic [3:0] res_ch_r, res_ch_nxt;
   logic stat_r, stat_nxt;
   logic mask_r, mask_nxt;
   logic irq_r, irq_nxt;
   logic busy_r, busy_nxt;
   logic start_r, start_nxt;
   logic [3:0] ch_r, ch_nxt;
   logic [1:0] kind_r, kind_nxt;
   logic [1:0] ref_r, ref_nxt;
   logic [9:0] rate_r, rate_nxt;
   logic [3:0] res_r, res_nxt;
   logic extra_r, extra_nxt;

   adcsx_avmm u_avmm (
      .clock(clock),
      .rstn(rstn),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .rd_data(rd_data),
      .acc_wr(acc_wr),
      .acc_idx(acc_idx),
      .acc_wdata(acc_wdata)
   );

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      case (acc_idx)
         adcsx_pkg::IDX_SEQ_CFG: rd_data = {sequence_reference_select_r, sequence_decimation_select_r, 4'(res_ch_r + 4'h1)};
         adcsx_pkg::IDX_EXT_CFG: rd_data = {extra_reference_select_r, extra_decimation_select_r, ech_r};
         adcsx_pkg::IDX_IRQ_STAT: rd_data = {2'h0, pend_r, busy_r, 3'h0, stat_r};
         adcsx_pkg::IDX_IRQ_MASK: rd_data = {7'h00, mask_r};
         default: rd_data = 8'h00;
      endcase
   end

   assign wr_seq = acc_wr && (acc_idx == adcsx_pkg::IDX_SEQ_CFG);
   assign wr_ext = acc_wr && (acc_idx == adcsx_pkg::IDX_EXT_CFG);

   // Sequence bounds
   always_comb begin
      if (sch_r <= adcsx_pkg::CH_SINGLE_LAST) begin
         first_ch = adcsx_pkg::CH_FIRST_SINGLE;
      end else if (sch_r <= adcsx_pkg::CH_DIFF_LAST) begin
         first_ch = adcsx_pkg::CH_DIFF_FIRST;
      end else begin
         first_ch = sch_r;
      end
   end
   assign last_ch = (sch_r > adcsx_pkg::CH_DIFF_LAST) || (seq_ch_r >= sch_r);

   // ----------------------------------------
   // Control next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      sequence_reference_select_nxt = sequence_reference_select_r;
      sequence_decimation_select_nxt = sequence_decimation_select_r;
      sch_nxt = sch_r;
      extra_reference_select_nxt = extra_reference_select_r;
      extra_decimation_select_nxt = extra_decimation_select_r;
      ech_nxt = ech_r;
      pend_nxt = pend_r;
      seq_ch_nxt = seq_ch_r;
      res_ch_nxt = res_ch_r;
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      start_nxt = 1'b0;
      ch_nxt = ch_r;
      kind_nxt = kind_r;
      ref_nxt = ref_r;
      rate_nxt = rate_r;
      res_nxt = res_r;
      extra_nxt = extra_r;
      if (wr_seq) begin
         sequence_reference_select_nxt = acc_wdata[adcsx_pkg::REF_LSB +: 2];
         sequence_decimation_select_nxt = acc_wdata[adcsx_pkg::DIV_LSB +: 2];
         sch_nxt = acc_wdata[adcsx_pkg::CH_LSB +: 4];
      end
      if (wr_ext) begin
         extra_reference_select_nxt = acc_wdata[adcsx_pkg::REF_LSB +: 2];
         extra_decimation_select_nxt = acc_wdata[adcsx_pkg::DIV_LSB +: 2];
         ech_nxt = acc_wdata[adcsx_pkg::CH_LSB +: 4];
         pend_nxt = 1'b1;
      end
      if (acc_wr && (acc_idx == adcsx_pkg::IDX_IRQ_MASK)) begin
         mask_nxt = acc_wdata[adcsx_pkg::STAT_EXTRA_DONE];
      end
      if (acc_wr && (acc_idx == adcsx_pkg::IDX_IRQ_STAT) && acc_wdata[adcsx_pkg::STAT_EXTRA_DONE]) begin
         stat_nxt = 1'b0;
      end
      case (state_r)
         adcsx_pkg::ADCSX_IDLE: begin
            if (pend_nxt) begin
               state_nxt = adcsx_pkg::ADCSX_EXTRA;
               start_nxt = 1'b1;
               ch_nxt = ech_nxt;
               kind_nxt = adcsx_pkg::chan_kind(ech_nxt);
               ref_nxt = extra_reference_select_nxt;
               rate_nxt = adcsx_pkg::dec_rate(extra_decimation_select_nxt);
               res_nxt = adcsx_pkg::dec_res(extra_decimation_select_nxt);
               extra_nxt = 1'b1;
            end else if (seq_start) begin
               state_nxt = adcsx_pkg::ADCSX_SEQ;
               seq_ch_nxt = first_ch;
               start_nxt = 1'b1;
               ch_nxt = first_ch;
               kind_nxt = adcsx_pkg::chan_kind(first_ch);
               ref_nxt = sequence_reference_select_nxt;
               rate_nxt = adcsx_pkg::dec_rate(sequence_decimation_select_nxt);
               res_nxt = adcsx_pkg::dec_res(sequence_decimation_select_nxt);
               extra_nxt = 1'b0;
            end
         end
         adcsx_pkg::ADCSX_SEQ: begin
            if (conv_done) begin
               res_ch_nxt = seq_ch_r;
               if (last_ch && pend_nxt) begin
                  state_nxt = adcsx_pkg::ADCSX_EXTRA;
                  start_nxt = 1'b1;
                  ch_nxt = ech_nxt;
                  kind_nxt = adcsx_pkg::chan_kind(ech_nxt);
                  ref_nxt = extra_reference_select_nxt;
                  rate_nxt = adcsx_pkg::dec_rate(extra_decimation_select_nxt);
                  res_nxt = adcsx_pkg::dec_res(extra_decimation_select_nxt);
                  extra_nxt = 1'b1;
               end else if (last_ch) begin
                  state_nxt = adcsx_pkg::ADCSX_IDLE;
               end else begin
                  seq_ch_nxt = 4'(seq_ch_r + 4'h1);
                  start_nxt = 1'b1;
                  ch_nxt = 4'(seq_ch_r + 4'h1);
                  kind_nxt = adcsx_pkg::chan_kind(4'(seq_ch_r + 4'h1));
                  ref_nxt = sequence_reference_select_nxt;
                  rate_nxt = adcsx_pkg::dec_rate(sequence_decimation_select_nxt);
                  res_nxt = adcsx_pkg::dec_res(sequence_decimation_select_nxt);
                  extra_nxt = 1'b0;
               end
            end
         end
         adcsx_pkg::ADCSX_EXTRA: begin
            if (conv_done) begin
               state_nxt = adcsx_pkg::ADCSX_IDLE;
               res_ch_nxt = ch_r;
               stat_nxt = 1'b1;
               pend_nxt = wr_ext;
               if (!wr_ext) begin
                  ech_nxt = adcsx_pkg::ECH_RST;
               end
            end
         end
         default: state_nxt = adcsx_pkg::ADCSX_IDLE;
      endcase
      busy_nxt = (state_nxt != adcsx_pkg::ADCSX_IDLE);
      irq_nxt = stat_nxt && mask_nxt;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= adcsx_pkg::ADCSX_IDLE;
         sequence_reference_select_r <= adcsx_pkg::SEQUENCE_REFERENCE_SELECT_RST;
         sequence_decimation_select_r <= adcsx_pkg::SEQUENCE_DECIMATION_SELECT_RST;
         sch_r <= adcsx_pkg::SCH_RST;
         extra_reference_select_r <= adcsx_pkg::EXTRA_REFERENCE_SELECT_RST;
         extra_decimation_select_r <= adcsx_pkg::EXTRA_DECIMATION_SELECT_RST;
         ech_r <= adcsx_pkg::ECH_RST;
         pend_r <= 1'b0;
         seq_ch_r <= 4'h0;
         res_ch_r <= adcsx_pkg::RESULT_CH_RST;
         stat_r <= 1'b0;
         mask_r <= 1'b0;
         irq_r <= 1'b0;
         busy_r <= 1'b0;
         start_r <= 1'b0;
         ch_r <= 4'h0;
         kind_r <= adcsx_pkg::KIND_SINGLE;
         ref_r <= 2'h0;
         rate_r <= 10'h000;
         res_r <= 4'h0;
         extra_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sequence_reference_select_r <= sequence_reference_select_nxt;
         sequence_decimation_select_r <= sequence_decimation_select_nxt;
         sch_r <= sch_nxt;
         extra_reference_select_r <= extra_reference_select_nxt;
         extra_decimation_select_r <= extra_decimation_select_nxt;
         ech_r <= ech_nxt;
         pend_r <= pend_nxt;
         seq_ch_r <= seq_ch_nxt;
         res_ch_r <= res_ch_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         busy_r <= busy_nxt;
         start_r <= start_nxt;
         ch_r <= ch_nxt;
         kind_r <= kind_nxt;
         ref_r <= ref_nxt;
         rate_r <= rate_nxt;
         res_r <= res_nxt;
         extra_r <= extra_nxt;
      end
   end

   assign conv_start = start_r;
   assign conv_channel = ch_r;
   assign conv_kind = kind_r;
   assign conv_reference = ref_r;
   assign conv_decim_rate = rate_r;
   assign conv_resolution = res_r;
   assign conv_extra = extra_r;
   assign result_channel = res_ch_r;
   assign busy = busy_r;
   assign irq = irq_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_seq_reference: assert property (start_r && !extra_r |-> ref_r == sequence_reference_select_r)
      else $error("sequence reference mismatch");
   a_seq_decim: assert property (start_r && !extra_r |-> rate_r == adcsx_pkg::dec_rate(sequence_decimation_select_r)
      && res_r == adcsx_pkg::dec_res(sequence_decimation_select_r))
      else $error("sequence decimation mismatch");
   a_ext_decim: assert property (start_r && extra_r |-> rate_r == adcsx_pkg::dec_rate(extra_decimation_select_r)
      && ref_r == extra_reference_select_r)
      else $error("extra decimation or reference mismatch");
   a_seq_first_ch: assert property (state_r == adcsx_pkg::ADCSX_IDLE && seq_start && !pend_nxt
      && sch_r <= adcsx_pkg::CH_DIFF_LAST |=> start_r && (ch_r == 4'h0 || ch_r == 4'h8))
      else $error("sequence did not begin at first channel");
   a_single_conv: assert property (state_r == adcsx_pkg::ADCSX_SEQ && sch_r > adcsx_pkg::CH_DIFF_LAST
      && conv_done |=> !start_r || extra_r)
      else $error("multi-channel sequence above end code 11");
   a_seq_step: assert property (state_r == adcsx_pkg::ADCSX_SEQ && conv_done && !last_ch
      |=> start_r && ch_r == 4'($past(seq_ch_r) + 4'h1))
      else $error("sequence step not ascending");
   a_sch_read: assert property (read && waitrequest && acc_idx == adcsx_pkg::IDX_SEQ_CFG
      |=> readdata[3:0] == 4'($past(res_ch_r) + 4'h1))
      else $error("sequence end readback wrong");
   a_idle_start: assert property (state_r == adcsx_pkg::ADCSX_IDLE && wr_ext
      |=> start_r && extra_r && state_r == adcsx_pkg::ADCSX_EXTRA ##1 !start_r)
      else $error("extra write while idle did not start");
   a_ext_defer: assert property (state_r == adcsx_pkg::ADCSX_SEQ |-> !(start_nxt && extra_nxt) || last_ch)
      else $error("extra started inside a sequence");
   a_ech_clear: assert property (state_r == adcsx_pkg::ADCSX_EXTRA && conv_done && !wr_ext
      |=> ech_r == 4'h0 && stat_r ##1 irq_r == mask_r || !stat_r)
      else $error("extra channel not cleared");
   a_seq_no_irq: assert property (state_r == adcsx_pkg::ADCSX_SEQ && !stat_r |=> !stat_r)
      else $error("sequence completion raised interrupt");

endmodule : adcsx_ctrl
`default_nettype wire

// >>> verif/test_adc_sequence_extra_ctrl.sv
// Self-checking bench for the converter sequence and extra-conversion control.
// Assumes adcsx_pkg and adcsx_ctrl are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module test_adc_sequence_extra_ctrl;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clock, rstn, read, write, seq_start, conv_done;
   logic waitrequest, conv_start, conv_extra, busy, irq;
   logic [9:0] address, conv_decim_rate;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable, conv_channel, conv_resolution, result_channel;
   logic [1:0] conv_kind, conv_reference, rf, dv;
   logic [3:0] ch, e, c;
   logic [7:0] q;
   logic [3:0] ends [3] = '{4'h3, 4'hA, 4'hD};
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed;

   adcsx_ctrl uut (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .seq_start(seq_start), .conv_done(conv_done), .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_kind(conv_kind), .conv_reference(conv_reference), .conv_decim_rate(conv_decim_rate),
      .conv_resolution(conv_resolution), .conv_extra(conv_extra), .result_channel(result_channel),
      .busy(busy), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ----------------------------------------
   // Timeout and verdict
   // ----------------------------------------
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [9:0] f_rate(input logic [1:0] k);
      f_rate = 10'h040 << k;
   endfunction : f_rate

   function automatic logic [3:0] f_res(input logic [1:0] k);
      case (k)
         2'h0: f_res = 4'h7;
         2'h1: f_res = 4'h9;
         2'h2: f_res = 4'hA;
         default: f_res = 4'hC;
      endcase
   endfunction : f_res

   function automatic logic [1:0] f_kind(input logic [3:0] k);
      f_kind = (k <= 4'h7) ? 2'h0 : (k <= 4'hB) ? 2'h1 : 2'h2;
   endfunction : f_kind

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be,
      output logic [7:0] rd);
      @(posedge clock);
      address <= {idx, 2'b00};
      read <= ~wr;
      write <= wr;
      writedata <= {24'h00_0000, d};
      byteenable <= be;
      // Hold the request until the rising edge that samples waitrequest low
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic pulse(input logic sq);
      @(posedge clock);
      if (sq) seq_start <= 1'b1;
      else conv_done <= 1'b1;
      @(posedge clock);
      seq_start <= 1'b0;
      conv_done <= 1'b0;
   endtask : pulse

   task automatic wait_start(input logic [3:0] k, input logic [1:0] r, input logic [1:0] v, input logic ex);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (conv_start !== 1'b1 && n < 2);
      check("conv_start", 32'h1, 32'(conv_start));
      check("conv_channel", 32'(k), 32'(conv_channel));
      check("conv_kind", 32'(f_kind(k)), 32'(conv_kind));
      check("conv_reference", 32'(r), 32'(conv_reference));
      check("conv_decim_rate", 32'(f_rate(v)), 32'(conv_decim_rate));
      check("conv_resolution", 32'(f_res(v)), 32'(conv_resolution));
      check("conv_extra", 32'(ex), 32'(conv_extra));
      check("busy", 32'h1, 32'(busy));
   endtask : wait_start

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 62670;
      rstn = 1'b0;
      address = 10'h000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'hF;
      seq_start = 1'b0;
      conv_done = 1'b0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      check("result_channel", 32'hF, 32'(result_channel));
      check("irq", 32'h0, 32'(irq));
      bus(1'b0, adcsx_pkg::IDX_SEQ_CFG, 8'h00, 4'hF, q);
      check("seq_cfg", 32'h10, 32'(q));
      bus(1'b0, adcsx_pkg::IDX_EXT_CFG, 8'h00, 4'hF, q);
      check("ext_cfg", 32'h00, 32'(q));
      bus(1'b0, 8'h10, 8'h00, 4'hF, q);
      check("unmapped", 32'h00, 32'(q));
      bus(1'b1, adcsx_pkg::IDX_EXT_CFG, 8'h05, 4'h0, q);
      @(negedge clock);
      check("busy", 32'h0, 32'(busy));
      $display("test reset done");
      // Every reference and decimation code on the extra conversion
      for (int i = 0; i < 16; i++) begin
         rf = 2'(i >> 2);
         dv = 2'(i);
         ch = (i < 3) ? 4'hC + 4'(i) : 4'($random(seed));
         bus(1'b1, adcsx_pkg::IDX_IRQ_MASK, 8'(i & 1), 4'hF, q);
         bus(1'b1, adcsx_pkg::IDX_EXT_CFG, {rf, dv, ch}, 4'hF, q);
         wait_start(ch, rf, dv, 1'b1);
         pulse(1'b0);
         @(negedge clock);
         check("busy", 32'h0, 32'(busy));
         check("irq", 32'(i & 1), 32'(irq));
         check("result_channel", 32'(ch), 32'(result_channel));
         bus(1'b0, adcsx_pkg::IDX_EXT_CFG, 8'h00, 4'hF, q);
         check("ext_cfg", 32'({rf, dv, 4'h0}), 32'(q));
         bus(1'b0, adcsx_pkg::IDX_IRQ_STAT, 8'h00, 4'hF, q);
         check("status", 32'h01, 32'(q));
         bus(1'b1, adcsx_pkg::IDX_IRQ_STAT, 8'h01, 4'hF, q);
         bus(1'b0, adcsx_pkg::IDX_IRQ_STAT, 8'h00, 4'hF, q);
         check("status", 32'h00, 32'(q));
         check("irq", 32'h0, 32'(irq));
      end
      $display("test extra done");
      // Single-ended, differential and single-source sequences
      for (int k = 0; k < 3; k++) begin
         e = ends[k];
         rf = 2'($random(seed));
         dv = 2'($random(seed));
         bus(1'b1, adcsx_pkg::IDX_SEQ_CFG, {rf, dv, e}, 4'hF, q);
         pulse(1'b1);
         for (c = (e <= 4'h7) ? 4'h0 : (e <= 4'hB) ? 4'h8 : e; c <= e; c++) begin
            wait_start(c, rf, dv, 1'b0);
            pulse(1'b0);
         end
         @(negedge clock);
         check("busy", 32'h0, 32'(busy));
         check("irq", 32'h0, 32'(irq));
         check("result_channel", 32'(e), 32'(result_channel));
         bus(1'b0, adcsx_pkg::IDX_SEQ_CFG, 8'h00, 4'hF, q);
         check("seq_cfg", 32'({rf, dv, e + 4'h1}), 32'(q));
         bus(1'b0, adcsx_pkg::IDX_IRQ_STAT, 8'h00, 4'hF, q);
         check("status", 32'h00, 32'(q));
      end
      $display("test sequence done");
      // Extra request while a sequence runs
      bus(1'b1, adcsx_pkg::IDX_SEQ_CFG, 8'h41, 4'hF, q);
      pulse(1'b1);
      wait_start(4'h0, 2'h1, 2'h0, 1'b0);
      bus(1'b1, adcsx_pkg::IDX_EXT_CFG, 8'hBE, 4'hF, q);
      pulse(1'b0);
      wait_start(4'h1, 2'h1, 2'h0, 1'b0);
      bus(1'b0, adcsx_pkg::IDX_IRQ_STAT, 8'h00, 4'hF, q);
      check("status", 32'h30, 32'(q));
      pulse(1'b0);
      wait_start(4'hE, 2'h2, 2'h3, 1'b1);
      pulse(1'b0);
      @(negedge clock);
      check("irq", 32'h1, 32'(irq));
      check("result_channel", 32'hE, 32'(result_channel));
      $display("test extra after sequence done");
      print_verdict();
   end
endmodule : test_adc_sequence_extra_ctrl
`default_nettype wire
